//--- design/general_purpose_io_port.sv
// general purpose i/o port: direction, latch, level read, analog, pull-up
// assumes an ahb-lite master and synchronous pin inputs on hclk
//
// Summary of operation
// - direction, level and latch registers per pin
// - direction bit selects input or driven output
// - latch write equals level register write
// - latch read returns stored latch values
// - level read returns actual pin levels
// - analog select disables digital input buffer
// - peripheral owns pin; gpio stops driving, readable
`timescale 1ns/1ps
module general_purpose_io_port
    import gpio_pkg::*;
#(
    parameter int WIDTH = 8            // pins in this port
)
(
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // peripheral ownership inputs
    input  wire logic [WIDTH-1:0] periph_out,
    input  wire logic [WIDTH-1:0] periph_oe,
    // pads
    input  wire logic [WIDTH-1:0] pad_in,
    output logic [WIDTH-1:0]      pad_out,
    output logic [WIDTH-1:0]      pad_oe,
    output logic [WIDTH-1:0]      pullup_en
);
    // register map, one aligned word each, low WIDTH bits used:
    //   direction  - 1 makes the pin an input, 0 drives the latch value
    //   level      - reads the sampled pins, writes go to the latch
    //   latch      - the general purpose output value, reads back as stored
    //   analog     - 1 gates the digital input buffer, pin reads zero
    //   pull-up    - 1 asks the pad for its weak pull-up
    //   peripheral - 1 hands the pad to the peripheral's value and enable
    // unmapped words read zero and ignore writes; the answer is always okay
    //
    // bus timing: writes have no wait state and land at the edge that ends
    // the data phase; reads insert one wait state so that the read value is
    // registered from the captured address before hready rises again
    // pad timing: a control write reaches pad_out and pad_oe one edge after
    // it lands, and a pin level reaches the level register at the very edge
    // that samples it; reads of the level register see that registered copy

    // register state
    logic [WIDTH-1:0] dir_r;          // pin_direction_reg
    logic [WIDTH-1:0] latch_r;        // output_latch_reg
    logic [WIDTH-1:0] analog_r;       // analog_select_reg
    logic [WIDTH-1:0] pullup_r;       // weak_pullup_reg
    logic [WIDTH-1:0] periph_r;       // peripheral enable per pin
    logic [WIDTH-1:0] level_r;        // sampled pin levels
    logic [WIDTH-1:0] level_nxt;
    logic [WIDTH-1:0] pad_out_nxt;
    logic [WIDTH-1:0] pad_oe_nxt;

    // data phase controls
    logic             wr_pend_r;
    logic [7:0]       addr_r;

    // decoded write strobes
    logic             wr_dir;
    logic             wr_latch;
    logic             wr_analog;
    logic             wr_pullup;
    logic             wr_periph;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] rd_sel;         // narrow read value
    logic [31:0]      hrdata_nxt;

    // address hits in the data phase
    logic             hit_dir;        // direction register addressed
    logic             hit_level;      // level register addressed
    logic             hit_latch;      // latch register addressed
    logic             hit_analog;     // analog select addressed
    logic             hit_pullup;     // pull-up enable addressed
    logic             hit_periph;     // peripheral enable addressed

    // next register values, held unless written
    logic [WIDTH-1:0] dir_nxt;
    logic [WIDTH-1:0] latch_nxt;
    logic [WIDTH-1:0] analog_nxt;
    logic [WIDTH-1:0] pullup_nxt;
    logic [WIDTH-1:0] periph_nxt;

    // read wait state control
    logic             rd_take;        // read address phase accepted
    logic             hreadyout_nxt;  // next ready to the bus

    // address phase capture
    gpio_ahb_decode u_dec
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .haddr     (haddr[7:0]),
        .wr_pend_r (wr_pend_r),
        .addr_r    (addr_r)
    );

    assign wdata = hwdata[WIDTH-1:0];

    // address hits; only the captured data phase address counts
    assign hit_dir    = (addr_r == OFF_DIR);
    assign hit_level  = (addr_r == OFF_LEVEL);
    assign hit_latch  = (addr_r == OFF_LATCH);
    assign hit_analog = (addr_r == OFF_ANALOG);
    assign hit_pullup = (addr_r == OFF_PULLUP);
    assign hit_periph = (addr_r == OFF_PERIPH);

    // both latch and level offsets write the same latch
    assign wr_latch  = wr_pend_r & (hit_latch | hit_level);
    assign wr_dir    = wr_pend_r & hit_dir;
    assign wr_analog = wr_pend_r & hit_analog;
    assign wr_pullup = wr_pend_r & hit_pullup;
    assign wr_periph = wr_pend_r & hit_periph;

    // next values; a write replaces the whole register, else it holds
    assign dir_nxt    = wr_dir    ? wdata : dir_r;
    assign latch_nxt  = wr_latch  ? wdata : latch_r;
    assign analog_nxt = wr_analog ? wdata : analog_r;
    assign pullup_nxt = wr_pullup ? wdata : pullup_r;
    assign periph_nxt = wr_periph ? wdata : periph_r;

    // read select; unmapped offsets read zero with okay
    // and-or form: the offsets differ, so at most one hit is high
    assign rd_sel = ({WIDTH{hit_dir}}    & dir_r)
                  | ({WIDTH{hit_level}}  & level_r)
                  | ({WIDTH{hit_latch}}  & latch_r)
                  | ({WIDTH{hit_analog}} & analog_r)
                  | ({WIDTH{hit_pullup}} & pullup_r)
                  | ({WIDTH{hit_periph}} & periph_r);
    assign hrdata_nxt = {{(32-WIDTH){1'b0}}, rd_sel};

    // a read is taken when selected, ready and active but not a write;
    // its data phase is stretched by one cycle so that hrdata can come
    // from a flop loaded from the captured address, at the cost of one
    // cycle per read
    assign rd_take       = hsel & hready & htrans[1] & ~hwrite;
    assign hreadyout_nxt = ~rd_take;

    // one cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_pin
            gpio_pin_cell u_cell
            (
                .dir_in      (dir_r[gi]),
                .latch_val   (latch_r[gi]),
                .analog_sel  (analog_r[gi]),
                .periph_en   (periph_r[gi]),
                .periph_out  (periph_out[gi]),
                .periph_oe   (periph_oe[gi]),
                .pad_in      (pad_in[gi]),
                .pad_out_nxt (pad_out_nxt[gi]),
                .pad_oe_nxt  (pad_oe_nxt[gi]),
                .level_nxt   (level_nxt[gi])
            );
        end
    endgenerate

    // direction register; resets to all inputs so no pin drives early
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_r <= RST_DIR[WIDTH-1:0];
        end
        else
        begin
            dir_r <= dir_nxt;
        end
    end

    // output latch; written through either the latch or the level word
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            latch_r <= RST_LATCH[WIDTH-1:0];
        end
        else
        begin
            latch_r <= latch_nxt;
        end
    end

    // analog select; set bits gate the digital input buffer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            analog_r <= RST_ANALOG[WIDTH-1:0];
        end
        else
        begin
            analog_r <= analog_nxt;
        end
    end

    // weak pull-up enables
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pullup_r <= RST_PULLUP[WIDTH-1:0];
        end
        else
        begin
            pullup_r <= pullup_nxt;
        end
    end

    // peripheral ownership per pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            periph_r <= RST_PERIPH[WIDTH-1:0];
        end
        else
        begin
            periph_r <= periph_nxt;
        end
    end

    // pin sampling; analog pins are forced low before the flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            level_r <= '0;
        end
        else
        begin
            level_r <= level_nxt;
        end
    end

    // pad drive; the pad path lags its control write by one cycle so that
    // pad_out and pad_oe come straight from flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pad_out <= '0;
            pad_oe  <= '0;
        end
        else
        begin
            pad_out <= pad_out_nxt;
            pad_oe  <= pad_oe_nxt;
        end
    end

    // pull-up enable to the pad, registered like the other pad controls
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pullup_en <= '0;
        end
        else
        begin
            pullup_en <= pullup_r;
        end
    end

    // read data; loads during the read wait state and stands with hready
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else
        begin
            hrdata <= hrdata_nxt;
        end
    end

    // bus handshake; ready drops for one cycle after a read is taken
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
        else
        begin
            hreadyout <= hreadyout_nxt;
            hresp     <= HRESP_OKAY;
        end
    end
endmodule // general_purpose_io_port

//--- design/gpio_pkg.sv
// package for the general purpose i/o port block
// assumes an ahb-lite slave with 32-bit data and word-aligned registers
package gpio_pkg;

    // register byte offsets (one aligned word each)
    localparam logic [7:0] OFF_DIR     = 8'h00;  // pin_direction_reg
    localparam logic [7:0] OFF_LEVEL   = 8'h04;  // pin_level_reg
    localparam logic [7:0] OFF_LATCH   = 8'h08;  // output_latch_reg
    localparam logic [7:0] OFF_ANALOG  = 8'h0C;  // analog_select_reg
    localparam logic [7:0] OFF_PULLUP  = 8'h10;  // weak_pullup_reg
    localparam logic [7:0] OFF_PERIPH  = 8'h14;  // peripheral ownership

    // decoded address width
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 7;

    // reset values: all pins inputs, latch clear, analog selected
    localparam logic [31:0] RST_DIR    = 32'hFFFFFFFF;
    localparam logic [31:0] RST_LATCH  = 32'h00000000;
    localparam logic [31:0] RST_ANALOG = 32'hFFFFFFFF;
    localparam logic [31:0] RST_PULLUP = 32'h00000000;
    localparam logic [31:0] RST_PERIPH = 32'h00000000;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage

//--- design/gpio_pin_cell.sv
// one pad cell's digital behaviour: driver select and input buffer gate
// assumes the pin input is synchronous to hclk
`timescale 1ns/1ps
module gpio_pin_cell
    import gpio_pkg::*;
(
    // controls for this pin
    input  wire logic dir_in,       // 1 = input, driver off
    input  wire logic latch_val,    // general purpose output value
    input  wire logic analog_sel,   // disables digital input buffer
    input  wire logic periph_en,    // peripheral owns the pin
    input  wire logic periph_out,   // peripheral output value
    input  wire logic periph_oe,    // peripheral drive enable
    // pad side
    input  wire logic pad_in,       // level at the pin
    output logic      pad_out_nxt,  // next pad output value
    output logic      pad_oe_nxt,   // next pad output enable
    output logic      level_nxt     // next sampled digital level
);
    // peripheral wins over the latch path; gpio drives only when dir is 0
    assign pad_out_nxt = periph_en ? periph_out : latch_val;
    assign pad_oe_nxt  = periph_en ? periph_oe : ~dir_in;
    // analog pins read zero so mid-rail levels never reach logic
    assign level_nxt   = analog_sel ? 1'b0 : pad_in;
endmodule // gpio_pin_cell

//--- design/gpio_ahb_decode.sv
// ahb-lite address phase capture for the port registers
// assumes a single master, whole-word single transfers
`timescale 1ns/1ps
module gpio_ahb_decode
    import gpio_pkg::*;
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // address phase
    input  wire logic       hsel,
    input  wire logic [1:0] htrans,
    input  wire logic       hwrite,
    input  wire logic       hready,
    input  wire logic [7:0] haddr,
    // captured data phase controls
    output logic            wr_pend_r,   // write data phase now
    output logic [7:0]      addr_r       // captured byte address
);
    logic       take;        // valid transfer accepted
    logic       wr_pend_nxt;
    logic [7:0] addr_nxt;

    assign take = hsel & hready & htrans[1];
    assign wr_pend_nxt = take & hwrite;
    assign addr_nxt    = take ? haddr : addr_r;

    // holding the address lets read data be registered from it during the wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end
        else
        begin
            wr_pend_r <= wr_pend_nxt;
            addr_r    <= addr_nxt;
        end
    end
endmodule // gpio_ahb_decode

//--- tb/gpio_port_chk.sv
// checker: shadow copies of the port registers, pin and read relations
// assumes one wait state per read, none per write
`timescale 1ns/1ps
module gpio_port_chk
    import gpio_pkg::*;
#(parameter int WIDTH = 8)
(
    // bus side
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    // pin side
    input wire logic [WIDTH-1:0] periph_out, periph_oe, pad_in, pad_out,
    input wire logic [WIDTH-1:0] pad_oe, pullup_en
);
    typedef logic [WIDTH-1:0] vec_t;
    vec_t dir_r, lat_r, an_r, pu_r, per_r;  // shadow registers
    logic w_r, r_r;                          // data phase kind
    logic [7:0] a_r;                         // data phase address
    wire vec_t d = hwdata[WIDTH-1:0];
    wire vec_t own = ~per_r & ~dir_r;        // gpio drives these
    wire vec_t pdr = per_r & periph_oe;      // peripheral drives these
    wire vec_t oe_x = own | pdr;
    wire vec_t lo_x = own & lat_r;
    wire vec_t po_x = pdr & periph_out;
    wire take = hsel & hready & htrans[1];
    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) {w_r, r_r, a_r} <= '0;
        else {w_r, r_r, a_r} <= {take & hwrite, take & ~hwrite, haddr[7:0]};
    // shadow registers load as the write data phase ends
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            {dir_r, an_r} <= '1;
            {lat_r, pu_r, per_r} <= '0;
        end
        else if (w_r)
            case (a_r)
                OFF_DIR: dir_r <= d;
                OFF_LEVEL, OFF_LATCH: lat_r <= d;
                OFF_ANALOG: an_r <= d;
                OFF_PULLUP: pu_r <= d;
                OFF_PERIPH: per_r <= d;
                default: ;
            endcase
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_in; (pad_oe & ~$past(oe_x)) == '0; endproperty
    a_in: assert property (p_in) else $error("undriven pin enabled");
    property p_drv; (pad_oe & $past(own)) == $past(own); endproperty
    a_drv: assert property (p_drv) else $error("output pin off");
    property p_lat; (pad_out & $past(own)) == $past(lo_x); endproperty
    a_lat: assert property (p_lat) else $error("pin not latch");
    property p_per; (pad_oe & $past(per_r)) == $past(pdr)
        && (pad_out & $past(pdr)) == $past(po_x); endproperty
    a_per: assert property (p_per) else $error("peripheral pin");
    property p_pu; pullup_en == $past(pu_r); endproperty
    a_pu: assert property (p_pu) else $error("pull-up enable");
    property p_hi; (hrdata >> WIDTH) == '0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits");
    property p_rlat; r_r && a_r == OFF_LATCH
        |=> hrdata[WIDTH-1:0] == $past(lat_r); endproperty
    a_rlat: assert property (p_rlat) else $error("latch read");
    property p_rlev; r_r && a_r == OFF_LEVEL
        |=> hrdata[WIDTH-1:0] == ($past(pad_in, 2) & ~$past(an_r, 2));
    endproperty
    a_rlev: assert property (p_rlev) else $error("level read");
    property p_rdy; hreadyout == !r_r; endproperty
    a_rdy: assert property (p_rdy) else $error("read wait state");
    property p_ok; hresp == HRESP_OKAY; endproperty
    a_ok: assert property (p_ok) else $error("bus response");
endmodule  // gpio_port_chk
bind general_purpose_io_port gpio_port_chk #(.WIDTH(WIDTH)) chk_i (.*);

//--- tb/pin_side_model.sv
// far side: outside drivers, pull-ups and floating pins
// assumes pad_oe high while the port drives a pin
`timescale 1ns/1ps
module pin_side_model
#(parameter int WIDTH = 8)
(
    // port side and outside drivers
    input wire logic hclk,
    input wire logic [WIDTH-1:0] pad_out, pad_oe, pullup_en, ext_val, ext_oe,
    output logic [WIDTH-1:0] pad_in
);
    logic flt_r = 1'b0;  // an undriven pin wanders every cycle
    always @(posedge hclk) flt_r <= ~flt_r;
    // port driver first, then outside driver, then pull-up or noise
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
        | (~pad_oe & ~ext_oe & (pullup_en | {WIDTH{flt_r}}));
endmodule  // pin_side_model

//--- tb/tb_general_purpose_io_port.sv
// testbench: random port settings, pin and read-back checks over the bus
// assumes the checker binds itself to the port
`timescale 1ns/1ps
module tb_general_purpose_io_port;
    import gpio_pkg::*;
    localparam int W = 8;
    typedef logic [W-1:0] v_t;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q, seed = 32'h0000C422;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = HSIZE_WORD;
    v_t periph_out = '0, periph_oe = '0, ext_val = '0, ext_oe = '0;
    v_t pad_in, pad_out, pad_oe, pullup_en, dir, lat, an, pul, per, m, o, k;
    int failures = 0, checked = 0, i;
    wire hready = hreadyout;  // single slave
    general_purpose_io_port #(.WIDTH(W)) DUT (.*);
    pin_side_model #(.WIDTH(W)) far (.*);
    always #50 hclk = ~hclk;
    function automatic v_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[W-1:0];
    endfunction
    // expected pin level; analog pins read zero
    function automatic v_t lvl(v_t oe, v_t out);
        return ((oe & out) | (~oe & ext_oe & ext_val)
            | (~oe & ~ext_oe & pul)) & ~an;
    endfunction
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input v_t seen, input v_t exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for hready at a rising edge
    task automatic wt();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                failures++;
                end_of_test();
            end
            @(posedge hclk);
        end
    endtask
    // one single word transfer; read data is taken as hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input v_t d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wt();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wt();
        if (!w)
            q = hrdata;
    endtask
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFF_DIR, '0);
        chk(q[W-1:0], 8'hFF);
        bus(1'b0, OFF_ANALOG, '0);
        chk(q[W-1:0], 8'hFF);
        bus(1'b1, 8'h18, 8'hA5);
        bus(1'b0, 8'h18, '0);
        chk(q[W-1:0], 8'h00);
        $display("reset and unmapped test done");
        for (i = 0; i < 40; i++)
        begin
            dir = rnd();
            lat = rnd();
            an = rnd();
            pul = rnd();
            per = rnd();
            if (i < 2)
            begin
                {dir, an} = '0;
                per = {W{i[0]}};
            end
            bus(1'b1, OFF_DIR, dir);
            bus(1'b1, i[0] ? OFF_LEVEL : OFF_LATCH, lat);
            bus(1'b1, OFF_ANALOG, an);
            bus(1'b1, OFF_PULLUP, pul);
            bus(1'b1, OFF_PERIPH, per);
            periph_out <= rnd();
            periph_oe <= rnd();
            ext_val <= rnd();
            ext_oe <= rnd();
            repeat (3) @(posedge hclk);
            m = (per & periph_oe) | (~per & ~dir);
            o = (per & periph_out) | (~per & lat);
            chk(pad_oe, m);
            chk(pad_out & m, o & m);
            chk(pullup_en, pul);
            bus(1'b0, OFF_LATCH, '0);
            chk(q[W-1:0], lat);
            bus(1'b0, OFF_LEVEL, '0);
            k = m | ext_oe | pul | an;
            chk(q[W-1:0] & k, lvl(m, o) & k);
        end
        $display("random port test done");
        // reset again mid-run: registers and pads must come back clean
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFF_DIR, '0);
        chk(q[W-1:0], RST_DIR[W-1:0]);
        chk(pad_oe, '0);
        chk(pullup_en, RST_PULLUP[W-1:0]);
        bus(1'b0, OFF_LATCH, '0);
        chk(q[W-1:0], RST_LATCH[W-1:0]);
        bus(1'b0, OFF_LEVEL, '0);
        chk(q[W-1:0], '0);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule  // tb_general_purpose_io_port
